/* hdl/int_add_div_regs.svh */
// constants for the integer add and divide unit
// assumes inclusion by the unit's design file; definitions only
`ifndef INT_ADD_DIV_REGS_SVH
`define INT_ADD_DIV_REGS_SVH

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define DW_MSB        63
`define DW_CARRY_LO   62
`define WORD_MSB      31
`define IMM_MSB       15
`define WORD_W        32
`define IMM_W         16
`define DW_W          64

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RESULT_RST    64'h0000_0000_0000_0000

`endif

/* hdl/int_add_div_pkg.sv */
// types for the integer add and divide unit
// assumes the constants header is in the include path
package int_add_div_pkg;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        op_none                    = 4'h0,
        long_sum_trapping_op       = 4'h1,
        long_imm_sum_trapping_op   = 4'h2,
        long_imm_sum_wrapping_op   = 4'h3,
        long_sum_wrapping_op       = 4'h4,
        long_signed_quotient_op    = 4'h5,
        long_unsigned_quotient_op  = 4'h6,
        word_signed_quotient_op    = 4'h7,
        word_unsigned_quotient_op  = 4'h8
    } op_t;

    // ------------------------------------------------------------------
    // issue bundle and add result
    // ------------------------------------------------------------------
    typedef struct packed {
        op_t         op;
        logic [63:0] src_a;
        logic [63:0] src_b;
        logic [15:0] imm;
        logic [4:0]  dest;
    } issue_t;

    typedef struct packed {
        logic        wr_en;
        logic [4:0]  dest;
        logic [63:0] value;
    } wb_t;

endpackage : int_add_div_pkg

/* hdl/integer_add_divide_unit.sv */
// integer add and divide datapath slice
// assumes the pipeline issues one decoded op per cycle and holds it
// Summary of operation
// - trapping register add, overflow on carry mismatch
// - trapping immediate add, sign-extended 16-bit immediate
// - overflow suppresses destination write
// - wrapping immediate add never overflows
// - wrapping register add never overflows
// - doubleword ops reserved in 32-bit user/supervisor
// - signed divides use two's complement operands
// - unsigned divides use zero-extended operands
// - quotient to bottom, remainder to upper
// - divides never overflow; zero divisor undefined
`timescale 1ns/1ps
`include "int_add_div_regs.svh"

module integer_add_divide_unit (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // issue side
    input  wire logic                   issue_valid,
    input  wire int_add_div_pkg::issue_t issue,
    input  wire logic                   mode_64,
    input  wire logic                   kernel_mode,
    // write-back and exceptions
    output int_add_div_pkg::wb_t        wb_q,
    output logic                        ovf_exc_q,
    output logic                        rsvd_exc_q,
    // result registers
    output logic [63:0]                 upper_result_reg,
    output logic [63:0]                 bottom_result_reg
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire int_add_div_pkg::op_t op = issue.op;
    wire is_dw = (op == int_add_div_pkg::long_sum_trapping_op)
              || (op == int_add_div_pkg::long_imm_sum_trapping_op)
              || (op == int_add_div_pkg::long_imm_sum_wrapping_op)
              || (op == int_add_div_pkg::long_sum_wrapping_op)
              || (op == int_add_div_pkg::long_signed_quotient_op)
              || (op == int_add_div_pkg::long_unsigned_quotient_op);
    wire is_imm = (op == int_add_div_pkg::long_imm_sum_trapping_op)
               || (op == int_add_div_pkg::long_imm_sum_wrapping_op);
    wire is_trap = (op == int_add_div_pkg::long_sum_trapping_op)
                || (op == int_add_div_pkg::long_imm_sum_trapping_op);
    wire is_add = is_imm || is_trap
               || (op == int_add_div_pkg::long_sum_wrapping_op);
    wire is_wdiv = (op == int_add_div_pkg::word_signed_quotient_op)
                || (op == int_add_div_pkg::word_unsigned_quotient_op);
    wire is_div = is_wdiv
               || (op == int_add_div_pkg::long_signed_quotient_op)
               || (op == int_add_div_pkg::long_unsigned_quotient_op);
    wire is_signed = (op == int_add_div_pkg::word_signed_quotient_op)
                  || (op == int_add_div_pkg::long_signed_quotient_op);

    // reserved when doubleword op in 32-bit non-kernel mode
    wire reserved = issue_valid && is_dw && !mode_64 && !kernel_mode;
    wire go = issue_valid && !reserved;

    // ------------------------------------------------------------------
    // adder with carry tap at bit 62
    // ------------------------------------------------------------------
    wire [63:0] imm_ext = {{(`DW_W - `IMM_W){issue.imm[`IMM_MSB]}},
                           issue.imm};
    wire [63:0] addend  = is_imm ? imm_ext : issue.src_b;
    // split at bit 62 so the carry into bit 63 is visible
    // without widening the whole sum to 65 bits
    wire [63:0] sum_lo  = {1'b0, issue.src_a[`DW_CARRY_LO:0]}
                        + {1'b0, addend[`DW_CARRY_LO:0]};
    wire        c62     = sum_lo[`DW_MSB];
    wire [1:0]  top     = {1'b0, issue.src_a[`DW_MSB]}
                        + {1'b0, addend[`DW_MSB]} + {1'b0, c62};
    wire [63:0] sum     = {top[0], sum_lo[`DW_CARRY_LO:0]};
    // carries out of 62 and 63 disagree
    wire        ovf     = is_trap && (c62 != top[1]);
    wire        wr_ok   = go && is_add && !ovf;

    // ------------------------------------------------------------------
    // divider operands: word forms use low 32 bits
    // ------------------------------------------------------------------
    wire [63:0] wa = is_signed
        ? {{`WORD_W{issue.src_a[`WORD_MSB]}}, issue.src_a[`WORD_MSB:0]}
        : {{`WORD_W{1'b0}}, issue.src_a[`WORD_MSB:0]};
    wire [63:0] wb = is_signed
        ? {{`WORD_W{issue.src_b[`WORD_MSB]}}, issue.src_b[`WORD_MSB:0]}
        : {{`WORD_W{1'b0}}, issue.src_b[`WORD_MSB:0]};
    wire [63:0] da = is_wdiv ? wa : issue.src_a;
    wire [63:0] db = is_wdiv ? wb : issue.src_b;

    // signed division via magnitudes, truncating toward zero
    // single-cycle: results stand at the next edge, so the
    // read spacing software keeps never matters in hardware
    wire        na   = is_signed && da[`DW_MSB];
    wire        nb   = is_signed && db[`DW_MSB];
    wire [63:0] ma   = na ? (~da + 64'h0000_0000_0000_0001) : da;
    wire [63:0] mb   = nb ? (~db + 64'h0000_0000_0000_0001) : db;
    // zero divisor gives an all-ones quotient, or 1 for a negative signed dividend; value is undefined
    wire        dz   = (mb == `RESULT_RST);
    wire [63:0] uq   = dz ? ~`RESULT_RST : ma / mb;
    wire [63:0] ur   = dz ? ma : ma % mb;
    wire [63:0] q    = (na ^ nb) ? (~uq + 64'h0000_0000_0000_0001) : uq;
    wire [63:0] r    = na ? (~ur + 64'h0000_0000_0000_0001) : ur;

    // word results extend from bit 31
    wire [63:0] q_out = is_wdiv
        ? {{`WORD_W{q[`WORD_MSB]}}, q[`WORD_MSB:0]} : q;
    wire [63:0] r_out = is_wdiv
        ? {{`WORD_W{r[`WORD_MSB]}}, r[`WORD_MSB:0]} : r;

    // ------------------------------------------------------------------
    // write-back and exception registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_q       <= '0;
            ovf_exc_q  <= 1'b0;
            rsvd_exc_q <= 1'b0;
        end else begin
            wb_q.wr_en <= wr_ok;
            wb_q.dest  <= issue.dest;
            wb_q.value <= sum;
            ovf_exc_q  <= go && ovf;
            rsvd_exc_q <= reserved;
        end
    end

    // result registers: quotient low, remainder high
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bottom_result_reg <= `RESULT_RST;
            upper_result_reg  <= `RESULT_RST;
        end else if (go && is_div) begin
            bottom_result_reg <= q_out;
            upper_result_reg  <= r_out;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // reference sums built apart from the carry-split adder
    wire [63:0] reg_chk = issue.src_a + issue.src_b;
    wire [63:0] imm_chk = issue.src_a + 64'($signed(issue.imm));

    a_ovf_blocks_write: assert property (@(posedge core_clk)
        disable iff (sys_rst) ovf_exc_q |-> !wb_q.wr_en)
        else $error("write-back with overflow");

    a_wrap_no_ovf: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (issue_valid && (op == int_add_div_pkg::long_sum_wrapping_op
          || op == int_add_div_pkg::long_imm_sum_wrapping_op))
        |=> !ovf_exc_q)
        else $error("wrapping add raised overflow");

    a_rsvd_mode: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (issue_valid && is_dw && !mode_64 && !kernel_mode)
        |=> rsvd_exc_q && !wb_q.wr_en)
        else $error("reserved op not trapped");

    a_rsvd_keeps: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        reserved |=> $stable(bottom_result_reg)
                  && $stable(upper_result_reg))
        else $error("reserved op changed results");

    a_add_sum: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (issue_valid && (op == int_add_div_pkg::long_sum_wrapping_op)
          && (mode_64 || kernel_mode))
        |=> wb_q.wr_en
            && wb_q.value == $past(issue.src_a) + $past(issue.src_b))
        else $error("register add sum wrong");

    a_imm_sum: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (issue_valid && op == int_add_div_pkg::long_imm_sum_wrapping_op
          && (mode_64 || kernel_mode))
        |=> wb_q.wr_en && !ovf_exc_q && wb_q.value == $past(imm_chk))
        else $error("immediate add sum wrong");

    a_ovf_sign: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && op == int_add_div_pkg::long_sum_trapping_op
          && issue.src_a[`DW_MSB] == issue.src_b[`DW_MSB]
          && reg_chk[`DW_MSB] != issue.src_a[`DW_MSB])
        |=> ovf_exc_q && !wb_q.wr_en)
        else $error("overflow missed");

    a_imm_ovf: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && op == int_add_div_pkg::long_imm_sum_trapping_op
          && issue.src_a[`DW_MSB] == issue.imm[`IMM_MSB]
          && imm_chk[`DW_MSB] != issue.src_a[`DW_MSB])
        |=> ovf_exc_q && !wb_q.wr_en)
        else $error("immediate overflow missed");

    a_div_nodz: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && op == int_add_div_pkg::long_unsigned_quotient_op
          && issue.src_b != `RESULT_RST)
        |=> bottom_result_reg == $past(issue.src_a) / $past(issue.src_b)
         && upper_result_reg == $past(issue.src_a) % $past(issue.src_b))
        else $error("unsigned divide wrong");

    a_word_udiv: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && op == int_add_div_pkg::word_unsigned_quotient_op
          && issue.src_b[`WORD_MSB:0] != 32'h0000_0000)
        |=> bottom_result_reg[`WORD_MSB:0]
            == $past(issue.src_a[`WORD_MSB:0])
             / $past(issue.src_b[`WORD_MSB:0]))
        else $error("word unsigned divide wrong");

    a_div_no_ovf: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (issue_valid && is_div) |=> !ovf_exc_q)
        else $error("divide raised overflow");

    a_word_ext: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && is_wdiv) |=>
        bottom_result_reg[`DW_MSB:`WORD_W]
            == {`WORD_W{bottom_result_reg[`WORD_MSB]}}
        && upper_result_reg[`DW_MSB:`WORD_W]
            == {`WORD_W{upper_result_reg[`WORD_MSB]}})
        else $error("word result not extended");

    a_signed_div: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (go && op == int_add_div_pkg::long_signed_quotient_op
          && issue.src_b != `RESULT_RST)
        |=> $signed(bottom_result_reg)
            == $signed($past(issue.src_a)) / $signed($past(issue.src_b)))
        else $error("signed divide wrong");

endmodule : integer_add_divide_unit

/* verif/pipe_model.sv */
// pipeline model that issues decoded ops to the add and divide unit
// assumes the bench calls issue_op and samples results after it returns
`timescale 1ns/1ps

module pipe_model (
    // clock
    input  wire logic                    core_clk,
    // issue side
    output int_add_div_pkg::issue_t      issue,
    output logic                         issue_valid,
    output logic                         mode_64,
    output logic                         kernel_mode
);
    // idle values at time zero
    initial begin
        issue_valid = 1'b0;
        issue       = '0;
        mode_64     = 1'b1;
        kernel_mode = 1'b0;
    end

    // one op for one cycle, launched and released at falling edges
    task automatic issue_op(input int_add_div_pkg::op_t op,
                            input logic [63:0] a, input logic [63:0] b,
                            input logic [15:0] imm, input logic m64,
                            input logic kern);
        logic wd;
        logic dv;
        wd = (op == int_add_div_pkg::word_signed_quotient_op) ||
             (op == int_add_div_pkg::word_unsigned_quotient_op);
        dv = wd || (op == int_add_div_pkg::long_signed_quotient_op) ||
             (op == int_add_div_pkg::long_unsigned_quotient_op);
        // two idle slots between earlier result reads and a divide
        if (dv) repeat (2) @(negedge core_clk);
        @(negedge core_clk);
        issue_valid = 1'b1;
        mode_64     = m64;
        kernel_mode = kern;
        issue.op    = op;
        issue.imm   = imm;
        issue.dest  = 5'h0b;
        // word operands stay sign-extended 32-bit values in 64-bit mode
        issue.src_a = (wd && m64) ? {{32{a[31]}}, a[31:0]} : a;
        issue.src_b = (wd && m64) ? {{32{b[31]}}, b[31:0]} : b;
        // results are sampled only after the op settles
        @(negedge core_clk);
        issue_valid = 1'b0;
        issue.op    = int_add_div_pkg::op_none;
        issue.src_a = ~issue.src_a;
        issue.src_b = ~issue.src_b;
    endtask : issue_op
endmodule : pipe_model

/* verif/test_integer_add_divide_unit.sv */
// self-checking bench for the integer add and divide unit
// assumes pipe_model drives issue at falling edges, latency of one cycle
`timescale 1ns/1ps

module test_integer_add_divide_unit;
    logic                    core_clk;
    logic                    sys_rst;
    logic                    issue_valid;
    logic                    mode_64;
    logic                    kernel_mode;
    logic                    ovf_exc_q;
    logic                    rsvd_exc_q;
    int_add_div_pkg::issue_t issue;
    int_add_div_pkg::wb_t    wb_q;
    logic [63:0]             upper_result_reg;
    logic [63:0]             bottom_result_reg;
    int                      miscompares = 0;
    int                      n_tests = 0;
    int                      cyc = 0;

    integer_add_divide_unit i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .issue_valid(issue_valid), .issue(issue), .mode_64(mode_64),
        .kernel_mode(kernel_mode), .wb_q(wb_q), .ovf_exc_q(ovf_exc_q),
        .rsvd_exc_q(rsvd_exc_q), .upper_result_reg(upper_result_reg),
        .bottom_result_reg(bottom_result_reg));
    pipe_model i_pipe (.core_clk(core_clk), .issue(issue),
        .issue_valid(issue_valid), .mode_64(mode_64),
        .kernel_mode(kernel_mode));

    // ------------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------------
    task automatic chk64(input string w, input logic [63:0] e, g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk64

    task automatic chk1(input string w, input logic e, g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", w, e, g);
        end
    endtask : chk1

    task automatic flags(input logic wr, ov, rs);
        chk1("wr_en", wr, wb_q.wr_en);
        chk1("ovf_exc_q", ov, ovf_exc_q);
        chk1("rsvd_exc_q", rs, rsvd_exc_q);
    endtask : flags

    task automatic res(input logic [63:0] q, r);
        chk64("bottom_result_reg", q, bottom_result_reg);
        chk64("upper_result_reg", r, upper_result_reg);
    endtask : res

    task automatic go(input int_add_div_pkg::op_t op,
                      input logic [63:0] a, b, input logic [15:0] imm,
                      input logic m64 = 1'b1, kern = 1'b0);
        i_pipe.issue_op(op, a, b, imm, m64, kern);
    endtask : go

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_add;
        go(int_add_div_pkg::long_sum_trapping_op, 64'h7fff_ffff_ffff_fffe,
           64'h1, 16'h0);
        flags(1'b1, 1'b0, 1'b0);
        chk64("sum", 64'h7fff_ffff_ffff_ffff, wb_q.value);
        chk64("dest", 64'h0b, 64'(wb_q.dest));
        go(int_add_div_pkg::long_sum_trapping_op, 64'h7fff_ffff_ffff_ffff,
           64'h1, 16'h0);
        flags(1'b0, 1'b1, 1'b0);
        go(int_add_div_pkg::long_sum_wrapping_op, 64'h7fff_ffff_ffff_ffff,
           64'h1, 16'h0);
        flags(1'b1, 1'b0, 1'b0);
        chk64("sum", 64'h8000_0000_0000_0000, wb_q.value);
        $display("add test done");
    endtask : t_add

    task automatic t_imm;
        go(int_add_div_pkg::long_imm_sum_trapping_op, 64'h10, 64'h0, 16'hfff0);
        flags(1'b1, 1'b0, 1'b0);
        chk64("sum", 64'h0, wb_q.value);
        go(int_add_div_pkg::long_imm_sum_trapping_op,
           64'h8000_0000_0000_0000, 64'h0, 16'h8000);
        flags(1'b0, 1'b1, 1'b0);
        go(int_add_div_pkg::long_imm_sum_wrapping_op,
           64'h8000_0000_0000_0000, 64'h0, 16'h8000);
        flags(1'b1, 1'b0, 1'b0);
        chk64("sum", 64'h7fff_ffff_ffff_8000, wb_q.value);
        $display("immediate test done");
    endtask : t_imm

    task automatic t_div;
        go(int_add_div_pkg::long_signed_quotient_op, -64'sd7, 64'h2, 16'h0);
        res(-64'sd3, -64'sd1);
        flags(1'b0, 1'b0, 1'b0);
        go(int_add_div_pkg::long_unsigned_quotient_op, -64'sd7, 64'h2, 16'h0);
        res(64'h7fff_ffff_ffff_fffc, 64'h1);
        go(int_add_div_pkg::word_signed_quotient_op, -64'sd7, 64'h2, 16'h0);
        res(-64'sd3, -64'sd1);
        go(int_add_div_pkg::word_unsigned_quotient_op, -64'sd7, 64'h1, 16'h0);
        res(-64'sd7, 64'h0);
        go(int_add_div_pkg::long_signed_quotient_op, 64'h5, 64'h0, 16'h0);
        flags(1'b0, 1'b0, 1'b0);
        $display("divide test done");
    endtask : t_div

    task automatic t_mode;
        go(int_add_div_pkg::long_unsigned_quotient_op, 64'h64, 64'h3, 16'h0);
        for (int k = 1; k <= 6; k++) begin
            go(int_add_div_pkg::op_t'(k[3:0]), 64'h7, 64'h2, 16'h0, 1'b0);
            flags(1'b0, 1'b0, 1'b1);
            res(64'h21, 64'h1);
        end
        go(int_add_div_pkg::long_sum_wrapping_op, 64'h1, 64'h2, 16'h0,
           1'b0, 1'b1);
        flags(1'b1, 1'b0, 1'b0);
        go(int_add_div_pkg::word_unsigned_quotient_op, 64'h7, 64'h2, 16'h0,
           1'b0);
        chk1("rsvd_exc_q", 1'b0, rsvd_exc_q);
        res(64'h3, 64'h1);
        $display("mode test done");
    endtask : t_mode

    // ------------------------------------------------------------------
    // verdict, clock, timeout and main sequence
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // cut a hang short well past the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        sys_rst = 1'b1;
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        res(64'h0, 64'h0);
        t_add();
        t_imm();
        t_div();
        t_mode();
        wrap_up();
    end
endmodule : test_integer_add_divide_unit
